// file: design/rtcc_control.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_control #(
  parameter int unsigned CLK_HZ = rtcc_pkg::CLK_HZ,
  parameter int unsigned XTAL_HZ = rtcc_pkg::XTAL_HZ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic power_on_pin,
  input wire logic low_supply_pin,
  input wire logic osc_halt_pin,
  input wire logic signed [7:0] osc_adj_ticks,
  output logic osc_adj_hold,
  input wire logic secs_rollover,
  input wire logic mins_rollover,
  input wire logic hours_rollover,
  input wire logic month_rollover,
  input wire logic alarm_w_match,
  input wire logic alarm_d_match,
  output logic sec_inc,
  output logic hour_24_mode,
  output logic supply_threshold_select,
  output logic test_mode,
  output logic irq_out_n,
  output logic slow_clock_out
);
  import rtcc_pkg::*;

  // Pin synchronisers
  logic [2:0] pin_meta_r, pin_sync_r;
  logic power_on_s, low_supply_s, osc_halt_s;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {power_on_pin, low_supply_pin, osc_halt_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign power_on_s = pin_sync_r[2];
  assign low_supply_s = pin_sync_r[1];
  assign osc_halt_s = pin_sync_r[0];

  // Register decode
  logic wr_ctrl_one, wr_ctrl_two, wr_seconds;

  assign wr_ctrl_one = reg_wr && (reg_addr == ADDR_CTRL_ONE);
  assign wr_ctrl_two = reg_wr && (reg_addr == ADDR_CTRL_TWO);
  assign wr_seconds = reg_wr && (reg_addr == ADDR_SECONDS);

  // Control one
  logic [7:0] ctrl_one_r, ctrl_one_nxt;
  logic power_on_flag_r;
  logic weekly_alarm_enable, daily_alarm_enable, clkout_disable_b;
  logic [2:0] periodic_select;

  always_comb begin
    ctrl_one_nxt = ctrl_one_r;
    if (power_on_flag_r) begin
      ctrl_one_nxt = CTRL1_RESET;
    end else if (wr_ctrl_one) begin
      ctrl_one_nxt = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_one_r <= CTRL1_RESET;
    end else begin
      ctrl_one_r <= ctrl_one_nxt;
    end
  end

  assign weekly_alarm_enable = ctrl_one_r[CTRL1_WEEKLY_EN_BIT];
  assign daily_alarm_enable = ctrl_one_r[CTRL1_DAILY_EN_BIT];
  assign clkout_disable_b = ctrl_one_r[CTRL1_CLKDIS_B_BIT];
  assign periodic_select = ctrl_one_r[CTRL1_SEL_LO_BIT +: 3];
  // Hour counter encodes from this bit
  assign hour_24_mode = ctrl_one_r[CTRL1_HOUR24_BIT];
  assign test_mode = ctrl_one_r[CTRL1_TEST_BIT];

  // Control two stored bits
  logic supply_thresh_r, supply_thresh_nxt;
  logic low_supply_flag_r, low_supply_flag_nxt;
  logic osc_halt_flag_r, osc_halt_flag_nxt;
  logic power_on_flag_nxt;
  logic clkout_disable_a_r, clkout_disable_a_nxt;

  always_comb begin
    supply_thresh_nxt = supply_thresh_r;
    low_supply_flag_nxt = low_supply_flag_r;
    osc_halt_flag_nxt = osc_halt_flag_r;
    power_on_flag_nxt = power_on_flag_r;
    clkout_disable_a_nxt = clkout_disable_a_r;
    if (wr_ctrl_two) begin
      supply_thresh_nxt = reg_wdata[CTRL2_THRESH_BIT];
      clkout_disable_a_nxt = reg_wdata[CTRL2_CLKDIS_A_BIT];
      osc_halt_flag_nxt = reg_wdata[CTRL2_OSC_HALT_BIT];
      if (!reg_wdata[CTRL2_LOW_SUPPLY_BIT]) begin
        low_supply_flag_nxt = 1'b0;
      end
      if (!reg_wdata[CTRL2_POWER_ON_BIT]) begin
        power_on_flag_nxt = 1'b0;
      end
    end
    if (low_supply_s) begin
      low_supply_flag_nxt = 1'b1;
    end
    if (osc_halt_s) begin
      osc_halt_flag_nxt = 1'b0;
    end
    if (power_on_s) begin
      power_on_flag_nxt = 1'b1;
    end
    if (power_on_flag_r) begin
      supply_thresh_nxt = 1'b0;
      low_supply_flag_nxt = 1'b0;
      clkout_disable_a_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_thresh_r <= 1'b0;
      low_supply_flag_r <= 1'b0;
      osc_halt_flag_r <= OSC_HALT_RESET;
      power_on_flag_r <= POWER_ON_RESET;
      clkout_disable_a_r <= 1'b0;
    end else begin
      supply_thresh_r <= supply_thresh_nxt;
      low_supply_flag_r <= low_supply_flag_nxt;
      osc_halt_flag_r <= osc_halt_flag_nxt;
      power_on_flag_r <= power_on_flag_nxt;
      clkout_disable_a_r <= clkout_disable_a_nxt;
    end
  end

  assign supply_threshold_select = supply_thresh_r;
  assign osc_adj_hold = power_on_flag_r;

  // Sub-second divider with minute adjustment
  logic signed [7:0] adj_lim;
  logic xtal_tick, xtal_phase, wave_1hz_low, wave_2hz_low;

  always_comb begin
    adj_lim = osc_adj_ticks;
    if (osc_adj_ticks > 8'sd0 && 32'(osc_adj_ticks) > ADJ_MAX_TICKS) begin
      adj_lim = 8'(ADJ_MAX_TICKS);
    end else if (osc_adj_ticks < 8'sd0 && 32'(-osc_adj_ticks) > ADJ_MAX_TICKS) begin
      adj_lim = -8'(ADJ_MAX_TICKS);
    end
  end

  rtcc_subsec_div #(
    .CLK_HZ(CLK_HZ),
    .XTAL_HZ(XTAL_HZ)
  ) u_div (
    .clk(clk),
    .arst_n(arst_n),
    .clear(wr_seconds),
    .adj_en(secs_rollover && !power_on_flag_r),
    .adj_ticks(adj_lim),
    .xtal_tick(xtal_tick),
    .xtal_phase(xtal_phase),
    .sec_inc(sec_inc),
    .wave_1hz_low(wave_1hz_low),
    .wave_2hz_low(wave_2hz_low)
  );

  // Periodic generator
  logic periodic_low, periodic_clear;

  assign periodic_clear = wr_ctrl_two && !reg_wdata[CTRL2_PERIODIC_BIT];

  rtcc_periodic u_periodic (
    .clk(clk),
    .arst_n(arst_n),
    .mode(periodic_select),
    .wave_1hz_low(wave_1hz_low),
    .wave_2hz_low(wave_2hz_low),
    .sec_inc(sec_inc),
    .secs_rollover(secs_rollover),
    .mins_rollover(mins_rollover),
    .hours_rollover(hours_rollover),
    .month_rollover(month_rollover),
    .flag_clear(periodic_clear),
    .periodic_low(periodic_low)
  );

  // Alarm flags, index 0 daily, 1 weekly
  logic [1:0] alarm_match, alarm_en, alarm_flag_r, alarm_pend_r;

  assign alarm_match = {alarm_w_match, alarm_d_match};
  assign alarm_en = {weekly_alarm_enable, daily_alarm_enable};

  for (genvar i = 0; i < 2; i++) begin : g_alarm
    logic [2:0] cnt_r, cnt_nxt;
    logic pend_nxt, flag_nxt, done;

    always_comb begin
      cnt_nxt = cnt_r;
      pend_nxt = alarm_pend_r[i];
      flag_nxt = alarm_flag_r[i];
      done = alarm_pend_r[i] && xtal_tick && (cnt_r == ALARM_CNT_LAST);
      if (wr_ctrl_two && !reg_wdata[CTRL2_DAILY_BIT + i]) begin
        flag_nxt = 1'b0;
      end
      if (alarm_match[i]) begin
        pend_nxt = 1'b1;
        cnt_nxt = 3'h0;
      end else if (done) begin
        pend_nxt = 1'b0;
        flag_nxt = 1'b1;
      end else if (alarm_pend_r[i] && xtal_tick) begin
        cnt_nxt = cnt_r + 3'h1;
      end
      if (!alarm_en[i]) begin
        pend_nxt = 1'b0;
        flag_nxt = 1'b0;
        cnt_nxt = 3'h0;
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_r <= 3'h0;
        alarm_pend_r[i] <= 1'b0;
        alarm_flag_r[i] <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        alarm_pend_r[i] <= pend_nxt;
        alarm_flag_r[i] <= flag_nxt;
      end
    end
  end

  // Pins
  logic irq_n_r, irq_n_nxt, slow_clk_r, slow_clk_nxt;

  always_comb begin
    irq_n_nxt = !(periodic_low || (|alarm_flag_r));
    slow_clk_nxt = (clkout_disable_a_r && clkout_disable_b) ? 1'b1 : xtal_phase;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_n_r <= 1'b1;
      slow_clk_r <= 1'b1;
    end else begin
      irq_n_r <= irq_n_nxt;
      slow_clk_r <= slow_clk_nxt;
    end
  end

  assign irq_out_n = irq_n_r;
  assign slow_clock_out = slow_clk_r;

  // Read data
  logic [7:0] rdata_r, rdata_nxt, ctrl_two_view;

  always_comb begin
    ctrl_two_view = {supply_thresh_r, low_supply_flag_r, osc_halt_flag_r,
                     power_on_flag_r, clkout_disable_a_r, periodic_low,
                     alarm_flag_r};
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL_ONE: rdata_nxt = ctrl_one_r;
        ADDR_CTRL_TWO: rdata_nxt = ctrl_two_view;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_level_low_kept;
    periodic_select[2] && periodic_low && !periodic_clear ##1 periodic_select[2];
  endsequence

  chk_pon_holds: assert property (power_on_flag_r |=> ctrl_one_r == 8'h00)
    else $error("Control one not held at zero by power-on flag");
  chk_pon_sticky: assert property (power_on_flag_r && !(wr_ctrl_two &&
      !reg_wdata[CTRL2_POWER_ON_BIT]) |=> power_on_flag_r)
    else $error("Power-on flag dropped without a zero write");
  chk_clkout_off: assert property (clkout_disable_a_r && clkout_disable_b
      |=> slow_clock_out)
    else $error("Clock output toggling while both disables set");
  chk_sel_off: assert property ((periodic_select == SEL_OFF)[*2] |-> !periodic_low)
    else $error("Periodic request active in off mode");
  chk_sel_fixed: assert property ((periodic_select == SEL_FIXED_LOW)[*2] |-> periodic_low)
    else $error("Periodic request not low in fixed mode");
  chk_level_fall: assert property (periodic_select == SEL_LEVEL_SEC && sec_inc
      |=> periodic_low ##1 !irq_out_n)
    else $error("Level interrupt missed seconds increment");
  chk_level_kept: assert property (s_level_low_kept |-> periodic_low)
    else $error("Level interrupt released without a clear");
  chk_sec_write: assert property (wr_seconds && periodic_select == SEL_PULSE_1HZ
      ##1 periodic_select == SEL_PULSE_1HZ |-> ##1 periodic_low)
    else $error("Seconds write did not drive pulse output low");
  chk_alarm_off: assert property (!weekly_alarm_enable |=> !alarm_flag_r[1])
    else $error("Weekly alarm flag set while disabled");
  chk_irq_alarm: assert property (alarm_flag_r[0] |=> !irq_out_n)
    else $error("Daily alarm flag did not pull the interrupt low");
endmodule
`default_nettype wire

// file: design/rtcc_pkg.sv
// Notes on behaviour
// - Control one bit layout, readback, cleared by power-on
// - Alarm enable bits gate each alarm circuit
// - Hour format bit: 0 twelve, 1 twenty-four
// - Twelve-hour BCD adds 20 for afternoon
// - Clock output off only when both disables set
// - Select codes 0-3: off, low, 2 Hz, 1 Hz
// - Select codes 4-7: second, minute, hour, month levels
// - Seconds increment lags pulse falling edge 92 us
// - Seconds write clears divider, output goes low
// - Level mode falling edge at seconds increment
// - Adjustment changes one period every minute
// - Control two bit layout and power-up values
// - Threshold select picks supply monitor level
// - Power-on flag holds control bits at zero
// - Periodic flag tracks output; level-mode zero clears
// - Alarm flag sets 61 us after match
// - Power-on flag cleared only by writing zero
package rtcc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned XTAL_HZ = 32_768;
  localparam int unsigned US_PER_S = 1_000_000;

  localparam logic [3:0] ADDR_SECONDS = 4'h0;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'he;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'hf;

  localparam int CTRL1_WEEKLY_EN_BIT = 7;
  localparam int CTRL1_DAILY_EN_BIT = 6;
  localparam int CTRL1_HOUR24_BIT = 5;
  localparam int CTRL1_CLKDIS_B_BIT = 4;
  localparam int CTRL1_TEST_BIT = 3;
  localparam int CTRL1_SEL_LO_BIT = 0;
  localparam logic [7:0] CTRL1_RESET = 8'h00;

  localparam int CTRL2_THRESH_BIT = 7;
  localparam int CTRL2_LOW_SUPPLY_BIT = 6;
  localparam int CTRL2_OSC_HALT_BIT = 5;
  localparam int CTRL2_POWER_ON_BIT = 4;
  localparam int CTRL2_CLKDIS_A_BIT = 3;
  localparam int CTRL2_PERIODIC_BIT = 2;
  localparam int CTRL2_WEEKLY_BIT = 1;
  localparam int CTRL2_DAILY_BIT = 0;
  localparam logic POWER_ON_RESET = 1'b1;
  localparam logic OSC_HALT_RESET = 1'b0;

  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_FIXED_LOW = 3'h1;
  localparam logic [2:0] SEL_PULSE_2HZ = 3'h2;
  localparam logic [2:0] SEL_PULSE_1HZ = 3'h3;
  localparam logic [2:0] SEL_LEVEL_SEC = 3'h4;
  localparam logic [2:0] SEL_LEVEL_MIN = 3'h5;
  localparam logic [2:0] SEL_LEVEL_HOUR = 3'h6;
  localparam logic [2:0] SEL_LEVEL_MONTH = 3'h7;

  localparam int unsigned SEC_DELAY_US = 92;
  localparam int unsigned ALARM_DELAY_US = 61;
  localparam int unsigned ADJ_MAX_NS = 3_784_000;
  localparam int unsigned SEC_DELAY_TICKS =
    (SEC_DELAY_US * XTAL_HZ + US_PER_S / 2) / US_PER_S;
  localparam int unsigned ALARM_DELAY_TICKS =
    (ALARM_DELAY_US * XTAL_HZ + US_PER_S / 2) / US_PER_S;
  localparam int unsigned ADJ_MAX_TICKS =
    32'((longint'(ADJ_MAX_NS) * XTAL_HZ + 64'd500_000_000) / 64'd1_000_000_000);

  localparam logic [15:0] SUBSEC_LAST = 16'h7fff;
  localparam logic [15:0] SUBSEC_HALF = 16'h4000;
  localparam logic [15:0] SUBSEC_QUARTER = 16'h2000;
  localparam logic [15:0] SUBSEC_3QUARTER = 16'h6000;
  localparam logic [15:0] SUBSEC_INC_AT = 16'(SEC_DELAY_TICKS);
  localparam logic [2:0] ALARM_CNT_LAST = 3'(ALARM_DELAY_TICKS - 1);
endpackage

// file: design/rtcc_subsec_div.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_subsec_div #(
  parameter int unsigned CLK_HZ = rtcc_pkg::CLK_HZ,
  parameter int unsigned XTAL_HZ = rtcc_pkg::XTAL_HZ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic adj_en,
  input wire logic signed [7:0] adj_ticks,
  output logic xtal_tick,
  output logic xtal_phase,
  output logic sec_inc,
  output logic wave_1hz_low,
  output logic wave_2hz_low
);
  import rtcc_pkg::*;

  localparam int ACC_W = $clog2(CLK_HZ) + 1;

  if (4 * XTAL_HZ > CLK_HZ) begin : g_bad_rate
    $error("Clock too slow for crystal rate");
  end

  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic [ACC_W:0] sum;
  logic half_tick, tick;
  logic phase_r, phase_nxt;
  logic [15:0] subsec_r, subsec_nxt, adj16, last, half;
  logic tick_r, sec_inc_r, w1_r, w2_r;
  logic sec_inc_nxt, w1_nxt, w2_nxt;

  always_comb begin
    sum = {1'b0, acc_r} + (ACC_W + 1)'(2 * XTAL_HZ);
    half_tick = sum >= (ACC_W + 1)'(CLK_HZ);
    acc_nxt = half_tick ? ACC_W'(sum - (ACC_W + 1)'(CLK_HZ)) : sum[ACC_W-1:0];
    phase_nxt = half_tick ? ~phase_r : phase_r;
    tick = half_tick & phase_r;
    adj16 = adj_en ? 16'(adj_ticks) : 16'h0000;
    last = SUBSEC_LAST + adj16;
    half = SUBSEC_HALF + adj16;
    subsec_nxt = subsec_r;
    if (clear) begin
      subsec_nxt = 16'h0000;
    end else if (tick) begin
      subsec_nxt = (subsec_r >= last) ? 16'h0000 : subsec_r + 16'h0001;
    end
    sec_inc_nxt = tick && !clear && (subsec_nxt == SUBSEC_INC_AT);
    w1_nxt = subsec_nxt < half;
    w2_nxt = (subsec_nxt < SUBSEC_QUARTER) ||
             ((subsec_nxt >= half) && (subsec_nxt < SUBSEC_3QUARTER + adj16));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= '0;
      phase_r <= 1'b0;
      subsec_r <= 16'h0000;
      tick_r <= 1'b0;
      sec_inc_r <= 1'b0;
      w1_r <= 1'b0;
      w2_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      phase_r <= phase_nxt;
      subsec_r <= subsec_nxt;
      tick_r <= tick;
      sec_inc_r <= sec_inc_nxt;
      w1_r <= w1_nxt;
      w2_r <= w2_nxt;
    end
  end

  assign xtal_tick = tick_r;
  assign xtal_phase = phase_r;
  assign sec_inc = sec_inc_r;
  assign wave_1hz_low = w1_r;
  assign wave_2hz_low = w2_r;
endmodule
`default_nettype wire

// file: design/rtcc_periodic.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_periodic (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] mode,
  input wire logic wave_1hz_low,
  input wire logic wave_2hz_low,
  input wire logic sec_inc,
  input wire logic secs_rollover,
  input wire logic mins_rollover,
  input wire logic hours_rollover,
  input wire logic month_rollover,
  input wire logic flag_clear,
  output logic periodic_low
);
  import rtcc_pkg::*;

  logic low_r, low_nxt, event_hit;

  always_comb begin
    event_hit = 1'b0;
    low_nxt = 1'b0;
    unique case (mode)
      SEL_OFF: low_nxt = 1'b0;
      SEL_FIXED_LOW: low_nxt = 1'b1;
      SEL_PULSE_2HZ: low_nxt = wave_2hz_low;
      SEL_PULSE_1HZ: low_nxt = wave_1hz_low;
      SEL_LEVEL_SEC: event_hit = sec_inc;
      SEL_LEVEL_MIN: event_hit = sec_inc & secs_rollover;
      SEL_LEVEL_HOUR: event_hit = sec_inc & secs_rollover & mins_rollover;
      SEL_LEVEL_MONTH: event_hit = sec_inc & secs_rollover & mins_rollover &
                                   hours_rollover & month_rollover;
    endcase
    if (mode[2]) begin
      if (event_hit) begin
        low_nxt = 1'b1;
      end else if (flag_clear) begin
        low_nxt = 1'b0;
      end else begin
        low_nxt = low_r;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_r <= 1'b0;
    end else begin
      low_r <= low_nxt;
    end
  end

  assign periodic_low = low_r;
endmodule
`default_nettype wire

// file: verification/rtcc_host.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_host (
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  import rtcc_pkg::*;

  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // Byte write; released lines show inverted garbage
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= (a == ADDR_CTRL_ONE) ? (d & 8'hf7) : d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Byte read, data taken once registered
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/rtcc_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rtcc_control_tb;
  import rtcc_pkg::*;
  localparam int unsigned TB_CLK_HZ = 131_072;
  logic clk, arst_n, reg_wr, reg_rd, power_on_pin, low_supply_pin, osc_halt_pin;
  logic [3:0] reg_addr, roll, q;
  logic [7:0] reg_wdata, reg_rdata, d, v;
  logic [1:0] alm;
  logic signed [7:0] osc_adj;
  logic sec_inc, hour_24_mode, supply_threshold_select, irq_out_n, slow_clock_out, prev;
  logic test_mode, osc_adj_hold;
  logic [31:0] seed;
  int err_count, samples_checked, n;

  rtcc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  rtcc_control #(.CLK_HZ(TB_CLK_HZ), .XTAL_HZ(XTAL_HZ)) dut (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_on_pin(power_on_pin), .low_supply_pin(low_supply_pin),
    .osc_halt_pin(osc_halt_pin), .osc_adj_ticks(osc_adj), .osc_adj_hold(osc_adj_hold),
    .secs_rollover(roll[0]), .mins_rollover(roll[1]), .hours_rollover(roll[2]),
    .month_rollover(roll[3]), .alarm_w_match(alm[0]), .alarm_d_match(alm[1]),
    .sec_inc(sec_inc), .hour_24_mode(hour_24_mode),
    .supply_threshold_select(supply_threshold_select), .test_mode(test_mode),
    .irq_out_n(irq_out_n), .slow_clock_out(slow_clock_out));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Whether a level-mode code fires for a set of rollover qualifiers
  function automatic logic lvl_fire(input logic [2:0] c, input logic [3:0] r);
    case (c)
      SEL_LEVEL_SEC: return 1'b1;
      SEL_LEVEL_MIN: return r[0];
      SEL_LEVEL_HOUR: return r[0] & r[1];
      default: return &r;
    endcase
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wait_inc();
    n = 0;
    #1;
    while (sec_inc !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #500_000;
    err_count++;
    end_of_test();
  end

  initial begin
    arst_n = 1'b0;
    power_on_pin = 1'b0;
    low_supply_pin = 1'b0;
    osc_halt_pin = 1'b0;
    osc_adj = 8'sh00;
    roll = 4'h0;
    alm = 2'h0;
    err_count = 0;
    samples_checked = 0;
    seed = 32'hea2da495;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    host.rd(ADDR_CTRL_ONE, d);
    chk8(d, CTRL1_RESET);
    host.rd(ADDR_CTRL_TWO, d);
    chk8(d, 8'h10);
    chk1(irq_out_n, 1'b1);
    chk1(osc_adj_hold, 1'b1);
    host.wr(ADDR_CTRL_ONE, 8'hff);
    host.rd(ADDR_CTRL_ONE, d);
    chk8(d, 8'h00);
    host.wr(ADDR_CTRL_TWO, 8'h10);
    host.rd(ADDR_CTRL_TWO, d);
    chk8(d, 8'h10);
    host.wr(ADDR_CTRL_TWO, 8'h00);
    host.rd(ADDR_CTRL_TWO, d);
    chk8(d, 8'h00);
    chk1(osc_adj_hold, 1'b0);
    $display("power-on flag test done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = seed[7:0];
      host.wr(ADDR_CTRL_ONE, v);
      host.rd(ADDR_CTRL_ONE, d);
      chk8(d, v & 8'hf7);
      chk1(hour_24_mode, v[CTRL1_HOUR24_BIT]);
      chk1(test_mode, 1'b0);
    end
    $display("readback test done");
    for (int c = 0; c < 4; c++) begin
      host.wr(ADDR_CTRL_ONE, {3'h0, c[0], 3'h0, c[1]});
      host.wr(ADDR_CTRL_TWO, {4'h0, c[1], 3'h0});
      ticks(3);
      chk1(irq_out_n, !c[1]);
      n = 0;
      prev = slow_clock_out;
      repeat (12) begin
        ticks(1);
        if (slow_clock_out !== prev) n++;
        prev = slow_clock_out;
      end
      chk1(n != 0, !(c[0] & c[1]));
      chk1(slow_clock_out | !(c[0] & c[1]), 1'b1);
      host.rd(ADDR_CTRL_TWO, d);
      chk8(d, {4'h0, c[1], c[1], 2'b00});
    end
    $display("fixed codes and clock output test done");
    for (int c = 2; c < 4; c++) begin
      host.wr(ADDR_CTRL_ONE, 8'(c) | 8'h20);
      host.wr(ADDR_SECONDS, 8'h00);
      wait_inc();
      chk1(n >= 6 && n <= 16, 1'b1);
      chk1(irq_out_n, 1'b0);
      host.wr(ADDR_CTRL_TWO, 8'h00);
      ticks(3);
      chk1(irq_out_n, 1'b0);
    end
    $display("pulse mode test done");
    for (int c = 4; c < 8; c++) begin
      host.wr(ADDR_CTRL_ONE, 8'(c));
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        q = (k == 0) ? 4'h0 : (k == 1) ? seed[3:0] : 4'hf;
        @(posedge clk);
        roll <= q;
        osc_adj <= seed[15:8];
        host.wr(ADDR_CTRL_TWO, 8'h00);
        ticks(3);
        chk1(irq_out_n, 1'b1);
        host.wr(ADDR_SECONDS, 8'h00);
        wait_inc();
        chk1(irq_out_n, 1'b1);
        ticks(3);
        chk1(irq_out_n, !lvl_fire(3'(c), q));
        host.rd(ADDR_CTRL_TWO, d);
        chk8(d, {5'h0, lvl_fire(3'(c), q), 2'b00});
      end
    end
    $display("level mode test done");
    for (int a = 0; a < 2; a++) begin
      host.wr(ADDR_CTRL_ONE, (a == 0) ? 8'h40 : 8'h80);
      host.wr(ADDR_CTRL_TWO, 8'h00);
      @(posedge clk);
      alm <= 2'(1 << a);
      @(posedge clk);
      alm <= 2'h0;
      ticks(20);
      chk1(irq_out_n, 1'b1);
      host.rd(ADDR_CTRL_TWO, d);
      chk8(d, 8'h00);
      host.wr(ADDR_CTRL_ONE, (a == 0) ? 8'h80 : 8'h40);
      @(posedge clk);
      alm <= 2'(1 << a);
      @(posedge clk);
      alm <= 2'h0;
      n = 0;
      #1;
      while (irq_out_n !== 1'b0 && n < 40) begin
        ticks(1);
        n++;
      end
      chk1(n >= 3 && n <= 16, 1'b1);
      host.rd(ADDR_CTRL_TWO, d);
      chk8(d, (a == 0) ? 8'h02 : 8'h01);
      host.wr(ADDR_CTRL_TWO, 8'h00);
      ticks(3);
      chk1(irq_out_n, 1'b1);
    end
    $display("alarm test done");
    @(posedge clk);
    low_supply_pin <= 1'b1;
    repeat (4) @(posedge clk);
    low_supply_pin <= 1'b0;
    host.rd(ADDR_CTRL_TWO, d);
    chk8(d, 8'h40);
    host.wr(ADDR_CTRL_TWO, 8'ha0);
    host.rd(ADDR_CTRL_TWO, d);
    chk8(d, 8'ha0);
    chk1(supply_threshold_select, 1'b1);
    @(posedge clk);
    osc_halt_pin <= 1'b1;
    repeat (4) @(posedge clk);
    osc_halt_pin <= 1'b0;
    host.rd(ADDR_CTRL_TWO, d);
    chk8(d, 8'h80);
    $display("supply monitor test done");
    host.wr(ADDR_CTRL_ONE, 8'h01);
    ticks(3);
    chk1(irq_out_n, 1'b0);
    @(posedge clk);
    power_on_pin <= 1'b1;
    repeat (4) @(posedge clk);
    power_on_pin <= 1'b0;
    ticks(3);
    chk1(irq_out_n, 1'b1);
    host.rd(ADDR_CTRL_ONE, d);
    chk8(d, 8'h00);
    host.rd(ADDR_CTRL_TWO, d);
    chk8(d, 8'h10);
    chk1(osc_adj_hold, 1'b1);
    $display("second power-on test done");
    end_of_test();
  end
endmodule
`default_nettype wire
